/* File: inc/rtc_pkg.sv */
// Constants, register map and state layout of the real-time timer and alarm unit
// Overview of operation
// RULE1: Crystal-valid status reads invalid for 2 ms after the oscillator is enabled.
// RULE2: 32-bit counter increments once per oscillator cycle while run is 1.
// RULE3: With auto-reset on, counter clears one oscillator cycle after an alarm match.
// RULE4: Writing 1 to the alarm flag control bit enables auto-reset.
// RULE5: Software programs the alarm value one less than the wanted interval.
// RULE6: Set and capture work while the counter keeps running.
// RULE7: Set copies holding registers into counter, then set bit clears to 0.
// RULE8: Capture snapshots counter into holding registers, then capture bit clears.
// RULE9: Six holding registers carry the counter value for set and capture; set and capture here use only the low four, hold[3:0].
// RULE10: Alarm event is raised only on exact 32-bit equality with compare value.
// RULE11: Alarm event serves as interrupt, wake-up and reset source.
// RULE12: Software disables alarm, writes compare value, then re-enables alarm.
// RULE13: Writing alarm enable as 0 clears the alarm event flag; here a match on the same tick keeps the flag set.
// RULE14: Re-enabling without changing compare value matches again only after wrap.
// RULE15: Alarm event flag stays set for at most one oscillator cycle.
// RULE16: Without auto-reset the counter wraps to zero and keeps counting.
// RULE17: Control register sits at offset 0x04.
// RULE18: Control bits 7..0: osc enable, detector enable, fail, run, alarm en, flag, set, capture.
// RULE19: Detector on: fail flag sets if oscillator stays high or low over 100 us.
// RULE20: Flag bit reads alarm event state; writing it only sets auto-reset.
// RULE21: Run 0 stops and holds the counter; run 1 lets it count.
// RULE22: Set and capture act on oscillator cycles; completion then clears the request.
package rtc_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BLANK_TIME_MS = 2;
    localparam int unsigned BLANK_CYCLES = BLANK_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned MISS_TIME_US = 100;
    localparam int unsigned MISS_CYCLES = MISS_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned WAIT_W = 20;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned HOLD_NUM = 6;
    localparam logic [7:0] CTRL_OFS = 8'h04;
    localparam logic [7:0] HOLD_BASE_OFS = 8'h08;
    localparam logic [7:0] ALARM_OFS = 8'h20;
    localparam logic [7:0] XTAL_OFS = 8'h24;

    localparam int unsigned CTL_CAP_BIT = 0;
    localparam int unsigned CTL_SET_BIT = 1;
    localparam int unsigned CTL_FLAG_BIT = 2;
    localparam int unsigned CTL_AEN_BIT = 3;
    localparam int unsigned CTL_RUN_BIT = 4;
    localparam int unsigned CTL_FAIL_BIT = 5;
    localparam int unsigned CTL_MCEN_BIT = 6;
    localparam int unsigned CTL_OSCEN_BIT = 7;
    localparam int unsigned XTAL_VALID_BIT = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic osc_en;
        logic mc_en;
        logic fail;
        logic run;
        logic aen;
        logic flag;
        logic autoreset;
        logic set_req;
        logic cap_req;
        logic [HOLD_NUM-1:0][7:0] hold;
        logic [31:0] alarm;
        logic [31:0] timer;
        logic osc_prev;
        logic [WAIT_W-1:0] stall;
        logic [WAIT_W-1:0] blank;
        logic blank_done;
        logic xvalid;
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_s;

    // Every control bit, holding byte, compare value and bus flag resets to zero
    localparam state_s STATE_RESET = '0;

endpackage : rtc_pkg

/* File: core/rtc_timer_alarm_unit.sv */
// Real-time timer with set/capture transfers, equality alarm and oscillator monitors
`timescale 1ns/1ps
module rtc_timer_alarm_unit #(
    parameter int unsigned BLANK_CYCLES = rtc_pkg::BLANK_CYCLES,
    parameter int unsigned MISS_CYCLES = rtc_pkg::MISS_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic OSC_IN,
    input wire logic AMP_OK_IN,
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    output logic ALARM_EVENT_OUT,
    output logic OSC_FAIL_OUT,
    output logic OSC_ENABLE_OUT,
    output logic CRYSTAL_VALID_OUT
);

    localparam logic [rtc_pkg::WAIT_W-1:0] BLANK_LAST = rtc_pkg::WAIT_W'(BLANK_CYCLES - 1);
    localparam logic [rtc_pkg::WAIT_W-1:0] MISS_LAST = rtc_pkg::WAIT_W'(MISS_CYCLES);

    rtc_pkg::state_s q;
    rtc_pkg::state_s d;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    function automatic logic is_mapped(input logic [7:0] a);
        logic hit;
        hit = (a == rtc_pkg::CTRL_OFS) || (a == rtc_pkg::ALARM_OFS) ||
              (a == rtc_pkg::XTAL_OFS);
        for (int i = 0; i < int'(rtc_pkg::HOLD_NUM); i++) begin
            if (a == 8'(rtc_pkg::HOLD_BASE_OFS + 8'(4 * i))) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : is_mapped

    function automatic logic [7:0] ctl_image(input rtc_pkg::state_s s);
        logic [7:0] v;
        v = 8'h00;
        v[rtc_pkg::CTL_OSCEN_BIT] = s.osc_en;
        v[rtc_pkg::CTL_MCEN_BIT] = s.mc_en;
        v[rtc_pkg::CTL_FAIL_BIT] = s.fail;
        v[rtc_pkg::CTL_RUN_BIT] = s.run;
        v[rtc_pkg::CTL_AEN_BIT] = s.aen;
        v[rtc_pkg::CTL_FLAG_BIT] = s.flag; // RULE20
        v[rtc_pkg::CTL_SET_BIT] = s.set_req;
        v[rtc_pkg::CTL_CAP_BIT] = s.cap_req;
        return v;
    endfunction : ctl_image

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic tick;
    logic wr_fire;
    logic wr_ctl;
    logic [7:0] wd;
    logic [31:0] next_timer;
    logic [31:0] rd_val;
    logic [7:0] ra;

    always_comb begin
        d = q;
        tick = OSC_IN & ~q.osc_prev;
        wr_fire = q.aw_full & q.w_full & ~q.bvalid;
        wr_ctl = wr_fire & (q.aw_addr == rtc_pkg::CTRL_OFS) & q.w_strb[0];
        wd = q.w_data[7:0];
        next_timer = q.timer;
        rd_val = 32'h0000_0000;
        ra = S_AXI_ARADDR_IN;

        d.osc_prev = OSC_IN;

        // Oscillator tick: the counter domain runs on this one-cycle enable
        if (tick) begin
            if (q.set_req) begin
                next_timer = q.hold[3:0]; // RULE7 RULE9 RULE6
                d.set_req = 1'b0; // RULE22
            end else if (q.flag && q.autoreset) begin
                next_timer = 32'h0000_0000; // RULE3
            end else if (q.run) begin
                next_timer = q.timer + 32'h0000_0001; // RULE2 RULE16 RULE21
            end
            if (q.cap_req) begin
                d.hold[3:0] = q.timer; // RULE8 RULE9 RULE6
                d.cap_req = 1'b0; // RULE22
            end
            d.timer = next_timer;
            // Only a fresh arrival at the compare value counts, so a stopped counter
            // or a re-enable on a passed value never re-fires until the next wrap
            d.flag = q.aen && (next_timer != q.timer) && (next_timer == q.alarm); // RULE10 RULE14 RULE15
        end

        // Missing-clock detector: count system cycles without an oscillator edge
        if (OSC_IN != q.osc_prev) begin
            d.stall = '0;
        end else if (q.stall != MISS_LAST) begin
            d.stall = q.stall + 1'b1;
        end

        // Crystal-valid blanking restarts whenever the oscillator is switched off
        if (!q.osc_en) begin
            d.blank = '0;
            d.blank_done = 1'b0;
        end else if (q.blank == BLANK_LAST) begin
            d.blank_done = 1'b1; // RULE1
        end else begin
            d.blank = q.blank + 1'b1;
        end
        d.xvalid = q.osc_en & q.blank_done & AMP_OK_IN; // RULE1

        // Write address and data are taken in either order
        if (S_AXI_AWVALID_IN && !q.aw_full) begin
            d.aw_full = 1'b1;
            d.aw_addr = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && !q.w_full) begin
            d.w_full = 1'b1;
            d.w_data = S_AXI_WDATA_IN;
            d.w_strb = S_AXI_WSTRB_IN;
        end
        if (q.bvalid && S_AXI_BREADY_IN) begin
            d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = is_mapped(q.aw_addr) ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
        end

        // Control register write; requests pending from the tick above are kept
        if (wr_ctl) begin // RULE17 RULE18
            d.osc_en = wd[rtc_pkg::CTL_OSCEN_BIT];
            d.mc_en = wd[rtc_pkg::CTL_MCEN_BIT];
            d.run = wd[rtc_pkg::CTL_RUN_BIT]; // RULE21
            d.aen = wd[rtc_pkg::CTL_AEN_BIT];
            d.autoreset = wd[rtc_pkg::CTL_FLAG_BIT]; // RULE4 RULE20
            if (!wd[rtc_pkg::CTL_FAIL_BIT]) begin
                d.fail = 1'b0;
            end
            if (wd[rtc_pkg::CTL_SET_BIT]) begin
                d.set_req = 1'b1; // RULE7
            end
            if (wd[rtc_pkg::CTL_CAP_BIT]) begin
                d.cap_req = 1'b1; // RULE8
            end
            // A match on this very tick still wins over the disabling write
            if (!wd[rtc_pkg::CTL_AEN_BIT] && !(tick && d.flag)) begin
                d.flag = 1'b0; // RULE13
            end
        end

        // Holding and compare register writes, honouring byte strobes
        if (wr_fire) begin
            for (int i = 0; i < int'(rtc_pkg::HOLD_NUM); i++) begin
                if (q.aw_addr == 8'(rtc_pkg::HOLD_BASE_OFS + 8'(4 * i)) && q.w_strb[0]) begin
                    d.hold[i] = wd; // RULE9
                end
            end
            if (q.aw_addr == rtc_pkg::ALARM_OFS) begin
                for (int b = 0; b < 4; b++) begin
                    if (q.w_strb[b]) begin
                        d.alarm[8*b +: 8] = q.w_data[8*b +: 8];
                    end
                end
            end
        end

        // Fail flag set after the software clear so a same-cycle event wins
        if (q.mc_en && q.stall == MISS_LAST) begin
            d.fail = 1'b1; // RULE19
        end

        // Read channel: one word answered the cycle after the address is taken
        if (q.rvalid && S_AXI_RREADY_IN) begin
            d.rvalid = 1'b0;
        end
        if (S_AXI_ARVALID_IN && !q.rvalid) begin
            if (ra == rtc_pkg::CTRL_OFS) begin
                rd_val = {24'h000000, ctl_image(q)};
            end else if (ra == rtc_pkg::ALARM_OFS) begin
                rd_val = q.alarm;
            end else if (ra == rtc_pkg::XTAL_OFS) begin
                rd_val[rtc_pkg::XTAL_VALID_BIT] = q.xvalid; // RULE1
            end
            for (int i = 0; i < int'(rtc_pkg::HOLD_NUM); i++) begin
                if (ra == 8'(rtc_pkg::HOLD_BASE_OFS + 8'(4 * i))) begin
                    rd_val = {24'h000000, q.hold[i]};
                end
            end
            d.rvalid = 1'b1;
            d.rdata = rd_val;
            d.rresp = is_mapped(ra) ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            q <= rtc_pkg::STATE_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign S_AXI_AWREADY_OUT = ~q.aw_full;
    assign S_AXI_WREADY_OUT = ~q.w_full;
    assign S_AXI_BVALID_OUT = q.bvalid;
    assign S_AXI_BRESP_OUT = q.bresp;
    assign S_AXI_ARREADY_OUT = ~q.rvalid;
    assign S_AXI_RVALID_OUT = q.rvalid;
    assign S_AXI_RDATA_OUT = q.rdata;
    assign S_AXI_RRESP_OUT = q.rresp;
    // One flag feeds interrupt, wake-up and reset logic outside the block
    assign ALARM_EVENT_OUT = q.flag; // RULE11
    assign OSC_FAIL_OUT = q.fail;
    assign OSC_ENABLE_OUT = q.osc_en;
    assign CRYSTAL_VALID_OUT = q.xvalid;

endmodule : rtc_timer_alarm_unit

/* File: tb/rtc_timer_alarm_unit_chk.sv */
// Port-level timing checks for the timer and alarm unit
`timescale 1ns/1ps
module rtc_timer_alarm_unit_chk #(
    parameter int unsigned BLANK_CYCLES = 20,
    parameter int unsigned MISS_CYCLES = 10
) (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic OSC_IN,
    input wire logic S_AXI_AWVALID_IN,
    input wire logic S_AXI_AWREADY_OUT,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic [31:0] S_AXI_RDATA_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic ALARM_EVENT_OUT,
    input wire logic OSC_FAIL_OUT,
    input wire logic OSC_ENABLE_OUT,
    input wire logic CRYSTAL_VALID_OUT
);
    logic osc_q;
    logic [15:0] still_q;
    logic [19:0] on_q;
    // Saturates so a long stall never wraps back to a short one
    always_ff @(posedge CLK_IN) begin
        osc_q <= OSC_IN;
        if (SRST_IN || OSC_IN != osc_q) begin
            still_q <= 16'h0;
        end else if (still_q != 16'hFFFF) begin
            still_q <= still_q + 16'h1;
        end
        // Cycles since the oscillator was switched on, to bound the blanking end
        if (SRST_IN || !OSC_ENABLE_OUT) begin
            on_q <= 20'h0;
        end else if (on_q != 20'hFFFFF) begin
            on_q <= on_q + 20'h1;
        end
    end
    default clocking dc @(posedge CLK_IN);
    endclocking
    default disable iff (SRST_IN);
    sequence s_tick;
        $rose(OSC_IN);
    endsequence
    sequence s_blank;
        (!CRYSTAL_VALID_OUT) [*8];
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_aw_taken: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT |=> !S_AXI_AWREADY_OUT)
        else $error("write address taken twice");
    a_b_stands: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
        else $error("write response dropped early");
    a_r_stands: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
        |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data unstable");
    a_r_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
        else $error("read answer late");
    a_flag_short: assert property (ALARM_EVENT_OUT ##0 s_tick |=> !ALARM_EVENT_OUT)
        else $error("alarm flag held past one tick");
    a_flag_tick: assert property ($rose(ALARM_EVENT_OUT) |-> $past(OSC_IN) && !$past(OSC_IN, 2))
        else $error("alarm flag raised off a tick");
    a_fail_stuck: assert property ($rose(OSC_FAIL_OUT) |-> $past(still_q) >= MISS_CYCLES)
        else $error("fail flag set while oscillator moves");
    a_xtal_blank: assert property ($rose(OSC_ENABLE_OUT) |-> s_blank)
        else $error("crystal valid during blanking");
    a_xtal_late: assert property ($rose(CRYSTAL_VALID_OUT) |-> on_q >= BLANK_CYCLES)
        else $error("crystal valid before blanking ends");
endmodule : rtc_timer_alarm_unit_chk
bind rtc_timer_alarm_unit rtc_timer_alarm_unit_chk #(
    .BLANK_CYCLES(BLANK_CYCLES), .MISS_CYCLES(MISS_CYCLES)
) u_chk (
    .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .OSC_IN(OSC_IN), .S_AXI_AWVALID_IN(S_AXI_AWVALID_IN),
    .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
    .S_AXI_BREADY_IN(S_AXI_BREADY_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
    .ALARM_EVENT_OUT(ALARM_EVENT_OUT), .OSC_FAIL_OUT(OSC_FAIL_OUT),
    .OSC_ENABLE_OUT(OSC_ENABLE_OUT), .CRYSTAL_VALID_OUT(CRYSTAL_VALID_OUT)
);

/* File: tb/rtc_timer_alarm_unit_tb.sv */
// Self-checking bench for the timer and alarm unit
`timescale 1ns/1ps
module rtc_timer_alarm_unit_tb;
    logic clk, srst, osc, amp, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, alarm, fail, oscen, xvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int miscompares = 0;
    int checked = 0;
    // When set, the bus tasks raise the response ready only after the answer shows
    logic slow_ready = 1'b0;
    rtc_timer_alarm_unit #(.BLANK_CYCLES(20), .MISS_CYCLES(10)) u_dut (
        .CLK_IN(clk), .SRST_IN(srst), .OSC_IN(osc), .AMP_OK_IN(amp),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .ALARM_EVENT_OUT(alarm),
        .OSC_FAIL_OUT(fail), .OSC_ENABLE_OUT(oscen), .CRYSTAL_VALID_OUT(xvalid)
    );
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !slow_ready;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready));
        rsp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !slow_ready;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready));
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : rd
    // One oscillator tick spans four system cycles
    task automatic tick(input int n);
        repeat (n) begin
            osc <= 1'b1;
            repeat (2) @(posedge clk);
            osc <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : tick
    task automatic poll(input logic [7:0] m);
        logic [31:0] d;
        int n;
        n = 0;
        do begin
            rd(rtc_pkg::CTRL_OFS, d);
            n++;
        end while ((d[7:0] & m) != 8'h00 && n < 20);
        chk(d & {24'h0, m}, 32'h0);
    endtask : poll
    task automatic cap(input logic [7:0] c, output logic [31:0] t);
        logic [31:0] d;
        wr(rtc_pkg::CTRL_OFS, {24'h0, c | 8'h01});
        tick(1);
        poll(8'h01);
        for (int i = 0; i < 4; i++) begin
            rd(rtc_pkg::HOLD_BASE_OFS + 8'(4 * i), d);
            t[8 * i +: 8] = d[7:0];
        end
    endtask : cap
    task automatic setv(input logic [31:0] t);
        logic [31:0] d;
        for (int i = 0; i < 4; i++) wr(rtc_pkg::HOLD_BASE_OFS + 8'(4 * i), {24'h0, t[8 * i +: 8]});
        wr(rtc_pkg::CTRL_OFS, 32'h02);
        rd(rtc_pkg::CTRL_OFS, d);
        chk(d, 32'h02);
        tick(1);
        poll(8'h02);
    endtask : setv
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(rtc_pkg::CTRL_OFS, v);
        chk(v, 32'h0);
        rd(8'h00, v);
        chk({30'h0, rsp}, {30'h0, rtc_pkg::RESP_SLVERR});
        slow_ready = 1'b1;
        wr(rtc_pkg::ALARM_OFS, 32'hA5C3_0F01);
        chk({30'h0, rsp}, {30'h0, rtc_pkg::RESP_OKAY});
        // Lane 0 off: the alarm takes only byte 1, the control write is dropped
        wstrb <= 4'h2;
        wr(rtc_pkg::ALARM_OFS, 32'h0000_7700);
        wr(rtc_pkg::CTRL_OFS, 32'h0000_0010);
        wstrb <= 4'hF;
        rd(rtc_pkg::ALARM_OFS, v);
        chk(v, 32'hA5C3_7701);
        slow_ready = 1'b0;
        rd(rtc_pkg::CTRL_OFS, v);
        chk(v, 32'h0);
        wr(8'h00, 32'h0000_00FF);
        chk({30'h0, rsp}, {30'h0, rtc_pkg::RESP_SLVERR});
    endtask : t_reset
    task automatic t_setrun();
        setv(32'h1234_5678);
        cap(8'h00, v);
        chk(v, 32'h1234_5678);
        setv(32'hFFFF_FFFE);
        wr(rtc_pkg::CTRL_OFS, 32'h10);
        tick(3);
        cap(8'h10, v);
        chk(v, 32'h1);
        wr(rtc_pkg::CTRL_OFS, 32'h00);
        tick(3);
        cap(8'h00, v);
        chk(v, 32'h2);
    endtask : t_setrun
    task automatic t_alarm();
        wr(rtc_pkg::CTRL_OFS, 32'h00);
        wr(rtc_pkg::ALARM_OFS, 32'h5);
        wr(rtc_pkg::CTRL_OFS, 32'h1C);
        tick(2);
        chk({31'h0, alarm}, 32'h0);
        tick(1);
        chk({31'h0, alarm}, 32'h1);
        rd(rtc_pkg::CTRL_OFS, v);
        chk(v, 32'h1C);
        tick(1);
        chk({31'h0, alarm}, 32'h0);
        rd(rtc_pkg::CTRL_OFS, v);
        chk(v, 32'h18);
        cap(8'h1C, v);
        chk(v, 32'h0);
        tick(4);
        chk({31'h0, alarm}, 32'h1);
        wr(rtc_pkg::CTRL_OFS, 32'h10);
        chk({31'h0, alarm}, 32'h0);
        // Re-enabled while the stopped counter sits on the compare value
        wr(rtc_pkg::CTRL_OFS, 32'h08);
        tick(2);
        chk({31'h0, alarm}, 32'h0);
    endtask : t_alarm
    task automatic t_osc();
        wr(rtc_pkg::CTRL_OFS, 32'h80);
        rd(rtc_pkg::XTAL_OFS, v);
        chk(v, 32'h0);
        repeat (30) @(posedge clk);
        rd(rtc_pkg::XTAL_OFS, v);
        chk(v, 32'h10);
        chk({31'h0, xvalid}, 32'h1);
        chk({31'h0, oscen}, 32'h1);
        wr(rtc_pkg::CTRL_OFS, 32'hC0);
        repeat (20) @(posedge clk);
        rd(rtc_pkg::CTRL_OFS, v);
        chk(v, 32'hE0);
        chk({31'h0, fail}, 32'h1);
        // First write stops the detector, whose last set still wins; second clears
        wr(rtc_pkg::CTRL_OFS, 32'h80);
        wr(rtc_pkg::CTRL_OFS, 32'h80);
        chk({31'h0, fail}, 32'h0);
    endtask : t_osc
    task automatic complete_run();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial begin
        {srst, osc, awvalid, wvalid, bready, arvalid, rready} = 7'h01 << 6;
        amp = 1'b1;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_setrun();
        t_alarm();
        t_osc();
        complete_run();
    end
endmodule : rtc_timer_alarm_unit_tb
